// file: ctl_params.svh
// constants for the ready/checksum/pin-direction register bank
// assumes a byte-wide register port driven by the serial front end
`ifndef CTL_PARAMS_SVH
`define CTL_PARAMS_SVH
`define ADR_PIN_DIR    7'h0e
`define ADR_READY_CTL  7'h11
`define ADR_CSUM_CTL   7'h13
`define ADR_CSUM_VAL   7'h1d
`define RDY_PIN6_BIT   7
`define RDY_NORST_BIT  5
`define RDY_GAIN_BIT   3
`define RDY_RW_MASK    8'h00a8
`define RDY_FIXED      8'h0003
`define CSUM_EN_BIT    4
`define CSUM_AFT_BIT   2
`define CSUM_RW_MASK   8'h0014
`define CSUM_FIXED     8'h0000
`define DIR_RW_MASK    8'h007f
`define BYTE_ZERO      8'h0000
`endif

// file: ctl_pkg.sv
// types for the ready/checksum/pin-direction register bank
// assumes nothing beyond the constants header
`default_nettype none
package ctl_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CSUM = 2'b11
  } rdy_state_t;
endpackage
`default_nettype wire

// file: ctl_bank.sv
// register bank: data-ready routing, checksum control, pin directions
// assumes checksum engine and converter reads are reported by strobes
`include "ctl_params.svh"
`default_nettype none
module ctl_bank (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // register port
  input  wire ctl_pkg::reg_req_t req,
  output var  logic [7:0]       rdata_q,
  // converter and checksum engine
  input  wire logic             conv_done,
  input  wire logic             low_byte_read,
  input  wire logic             csum_byte_read,
  input  wire logic [7:0]       csum_current,
  output var  logic             csum_enable_q,
  output var  logic             csum_reset_q,
  output var  logic             gain_use_last_q,
  // general pins
  input  wire logic [6:0]       pin_out_val,
  output var  logic [6:0]       pin_oe_q,
  output var  logic [6:0]       pin_o_q,
  output var  logic             ready_n_q
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] dir_q, dir_d, rdy_q, rdy_d, ck_q, ck_d, rdata_d;
  logic       csum_rst_d, rel;
  ctl_pkg::rdy_state_t st_q, st_d;
  logic       ready_n_d;

  function automatic logic [7:0] merge(input logic [7:0] w, input logic [7:0] m,
                                       input logic [7:0] f);
    merge = (w & m) | f;
  endfunction

  always_comb begin
    dir_d = dir_q;
    rdy_d = rdy_q;
    ck_d  = ck_q;
    if (req.wr) begin
      case (req.addr)
        `ADR_PIN_DIR:   dir_d = merge(req.wdata, `DIR_RW_MASK, `BYTE_ZERO);
        // fixed bits forced: a careless host cannot break them
        `ADR_READY_CTL: rdy_d = merge(req.wdata, `RDY_RW_MASK, `RDY_FIXED);
        `ADR_CSUM_CTL:  ck_d  = merge(req.wdata, `CSUM_RW_MASK, `CSUM_FIXED);
        default:        ;
      endcase
    end
    rdata_d = rdata_q;
    if (req.rd) begin
      case (req.addr)
        `ADR_PIN_DIR:   rdata_d = dir_q;
        `ADR_READY_CTL: rdata_d = rdy_q;
        `ADR_CSUM_CTL:  rdata_d = ck_q;
        `ADR_CSUM_VAL:  rdata_d = csum_current;
        default:        rdata_d = `BYTE_ZERO;
      endcase
    end
  end

  // ****************************************
  // data-ready sequencing
  // ****************************************
  always_comb begin
    st_d = st_q;
    rel  = 1'b0;
    case (st_q)
      ctl_pkg::ST_IDLE: if (conv_done) st_d = ctl_pkg::ST_WAIT;
      ctl_pkg::ST_WAIT: begin
        if (low_byte_read) begin
          if (ck_q[`CSUM_AFT_BIT]) st_d = ctl_pkg::ST_CSUM;
          else begin
            st_d = ctl_pkg::ST_IDLE;
            rel  = 1'b1;
          end
        end
      end
      ctl_pkg::ST_CSUM: if (csum_byte_read) begin
        st_d = ctl_pkg::ST_IDLE;
        rel  = 1'b1;
      end
      default: st_d = ctl_pkg::ST_IDLE;
    endcase
    ready_n_d  = (st_d == ctl_pkg::ST_IDLE);
    csum_rst_d = (req.wr && req.addr == `ADR_CSUM_VAL)
               | (rel && !rdy_q[`RDY_NORST_BIT]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_q           <= `BYTE_ZERO;
      rdy_q           <= `RDY_FIXED;
      ck_q            <= `CSUM_FIXED;
      rdata_q         <= `BYTE_ZERO;
      st_q            <= ctl_pkg::ST_IDLE;
      ready_n_q       <= 1'b1;
      csum_reset_q    <= 1'b0;
      csum_enable_q   <= 1'b0;
      gain_use_last_q <= 1'b0;
      pin_oe_q        <= 7'h00;
      pin_o_q         <= 7'h00;
    end else begin
      dir_q           <= dir_d;
      rdy_q           <= rdy_d;
      ck_q            <= ck_d;
      rdata_q         <= rdata_d;
      st_q            <= st_d;
      ready_n_q       <= ready_n_d;
      csum_reset_q    <= csum_rst_d;
      csum_enable_q   <= ck_d[`CSUM_EN_BIT];
      gain_use_last_q <= rdy_d[`RDY_GAIN_BIT];
      // pin 6 muxed: data-ready overrides direction
      pin_oe_q        <= rdy_d[`RDY_PIN6_BIT] ? {1'b1, dir_d[5:0]} : dir_d[6:0];
      pin_o_q         <= rdy_d[`RDY_PIN6_BIT] ? {ready_n_d, pin_out_val[5:0]}
                                              : pin_out_val;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_rel_reset;
    @(posedge clk) disable iff (rst)
      (st_q != ctl_pkg::ST_IDLE && ready_n_d && !rdy_q[`RDY_NORST_BIT]) |=> csum_reset_q;
  endproperty
  a_rel_reset: assert property (p_rel_reset) else $error("no reset on release");

  property p_wr_reset;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == `ADR_CSUM_VAL) |=> csum_reset_q;
  endproperty
  a_wr_reset: assert property (p_wr_reset) else $error("write did not reset");

  property p_fixed;
    @(posedge clk) disable iff (rst)
      rdy_q[2:0] == 3'h3 && ck_q[3] == 1'b0 && rdy_q[6] == 1'b0 && dir_q[7] == 1'b0;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits changed");

  property p_pin6;
    @(posedge clk) disable iff (rst)
      rdy_q[`RDY_PIN6_BIT] |-> (pin_oe_q[6] && pin_o_q[6] == ready_n_q);
  endproperty
  a_pin6: assert property (p_pin6) else $error("pin 6 not data-ready");

  property p_aft;
    @(posedge clk) disable iff (rst)
      (st_q == ctl_pkg::ST_WAIT && low_byte_read && ck_q[`CSUM_AFT_BIT]) |=> !ready_n_q;
  endproperty
  a_aft: assert property (p_aft) else $error("released before checksum");

  property p_dir;
    @(posedge clk) disable iff (rst)
      pin_oe_q[5:0] == dir_q[5:0];
  endproperty
  a_dir: assert property (p_dir) else $error("direction mismatch");

  property p_en;
    @(posedge clk) disable iff (rst) csum_enable_q == ck_q[`CSUM_EN_BIT];
  endproperty
  a_en: assert property (p_en) else $error("enable mismatch");

  property p_gain;
    @(posedge clk) disable iff (rst) gain_use_last_q == rdy_q[`RDY_GAIN_BIT];
  endproperty
  a_gain: assert property (p_gain) else $error("gain select mismatch");

  // ****************************************
  // sequencing and register-port checks
  // ****************************************
  // these pin down each ready_n_q edge and the hold in ST_CSUM, so a broken next-state case there shows at once
  property p_conv_assert;
    @(posedge clk) disable iff (rst)
      (st_q == ctl_pkg::ST_IDLE && conv_done) |=> !ready_n_q;
  endproperty
  a_conv_assert: assert property (p_conv_assert) else $error("data-ready not asserted");

  property p_rel_low;
    @(posedge clk) disable iff (rst)
      (st_q == ctl_pkg::ST_WAIT && low_byte_read && !ck_q[`CSUM_AFT_BIT]) |=> ready_n_q;
  endproperty
  a_rel_low: assert property (p_rel_low) else $error("no release after low byte");

  property p_rel_csum;
    @(posedge clk) disable iff (rst)
      (st_q == ctl_pkg::ST_CSUM && csum_byte_read) |=> ready_n_q;
  endproperty
  a_rel_csum: assert property (p_rel_csum) else $error("no release after checksum");

  property p_hold_csum;
    @(posedge clk) disable iff (rst)
      (st_q == ctl_pkg::ST_CSUM && !csum_byte_read) |=> !ready_n_q;
  endproperty
  a_hold_csum: assert property (p_hold_csum) else $error("early release");

  property p_ready_idle;
    @(posedge clk) disable iff (rst)
      ready_n_q == (st_q == ctl_pkg::ST_IDLE);
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready level off state");

  property p_state_legal;
    @(posedge clk) disable iff (rst)
      (st_q == ctl_pkg::ST_IDLE || st_q == ctl_pkg::ST_WAIT || st_q == ctl_pkg::ST_CSUM);
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("illegal state");

  // release with auto reset off must stay quiet unless a write asks for it
  property p_norst;
    @(posedge clk) disable iff (rst)
      (st_q != ctl_pkg::ST_IDLE && ready_n_d && rdy_q[`RDY_NORST_BIT]
       && !(req.wr && req.addr == `ADR_CSUM_VAL)) |=> !csum_reset_q;
  endproperty
  a_norst: assert property (p_norst) else $error("reset while suppressed");

  property p_quiet;
    @(posedge clk) disable iff (rst)
      (!(req.wr && req.addr == `ADR_CSUM_VAL) && !(st_q != ctl_pkg::ST_IDLE && ready_n_d))
      |=> !csum_reset_q;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spurious checksum reset");

  property p_val_wr;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == `ADR_CSUM_VAL) |=> ($stable(dir_q) && $stable(rdy_q) && $stable(ck_q));
  endproperty
  a_val_wr: assert property (p_val_wr) else $error("checksum write stored");

  property p_rd_val;
    @(posedge clk) disable iff (rst)
      (req.rd && req.addr == `ADR_CSUM_VAL) |=> rdata_q == $past(csum_current);
  endproperty
  a_rd_val: assert property (p_rd_val) else $error("checksum read wrong");

  property p_rd_hold;
    @(posedge clk) disable iff (rst)
      !req.rd |=> $stable(rdata_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  property p_rd_dir;
    @(posedge clk) disable iff (rst)
      (req.rd && req.addr == `ADR_PIN_DIR) |=> rdata_q == $past(dir_q);
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("direction read wrong");

  property p_rd_rdy;
    @(posedge clk) disable iff (rst)
      (req.rd && req.addr == `ADR_READY_CTL) |=> rdata_q == $past(rdy_q);
  endproperty
  a_rd_rdy: assert property (p_rd_rdy) else $error("ready control read wrong");

  property p_rd_ck;
    @(posedge clk) disable iff (rst)
      (req.rd && req.addr == `ADR_CSUM_CTL) |=> rdata_q == $past(ck_q);
  endproperty
  a_rd_ck: assert property (p_rd_ck) else $error("checksum control read wrong");

  // unmapped reads must not leak stale data from an earlier read
  property p_rd_none;
    @(posedge clk) disable iff (rst)
      (req.rd && !(req.addr inside {`ADR_PIN_DIR, `ADR_READY_CTL, `ADR_CSUM_CTL, `ADR_CSUM_VAL}))
      |=> rdata_q == `BYTE_ZERO;
  endproperty
  a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");

  property p_dir_wr;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == `ADR_PIN_DIR) |=> dir_q == ($past(req.wdata) & `DIR_RW_MASK);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction write wrong");

  property p_rdy_wr;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == `ADR_READY_CTL)
      |=> rdy_q == (($past(req.wdata) & `RDY_RW_MASK) | `RDY_FIXED);
  endproperty
  a_rdy_wr: assert property (p_rdy_wr) else $error("ready control write wrong");

  property p_ck_wr;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == `ADR_CSUM_CTL) |=> ck_q == ($past(req.wdata) & `CSUM_RW_MASK);
  endproperty
  a_ck_wr: assert property (p_ck_wr) else $error("checksum control write wrong");

  property p_en_wr;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == `ADR_CSUM_CTL) |=> csum_enable_q == $past(req.wdata[`CSUM_EN_BIT]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable not taken");

  // ****************************************
  // pin 6 sharing checks
  // ****************************************
  property p_gp6;
    @(posedge clk) disable iff (rst)
      !rdy_q[`RDY_PIN6_BIT] |-> pin_oe_q[6] == dir_q[6];
  endproperty
  a_gp6: assert property (p_gp6) else $error("pin 6 direction ignored");

  // an input-configured pin 6 still drives once data-ready owns it
  property p_no_gp6;
    @(posedge clk) disable iff (rst)
      (rdy_q[`RDY_PIN6_BIT] && !dir_q[6]) |-> pin_oe_q[6];
  endproperty
  a_no_gp6: assert property (p_no_gp6) else $error("pin 6 left to general use");
endmodule
`default_nettype wire

// file: host_model.sv
// host model: issues single register writes and reads
// assumes the bank takes a request on the rising edge
`default_nettype none
module host_model (
  // bus
  input  wire logic              clk,
  input  wire logic [7:0]        rdata,
  output var  ctl_pkg::reg_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    if (a == 7'h11) d[2:0] = 3'h3;
    if (a == 7'h13) d[3] = 1'b0;
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// bench: host model and reference values around the bank
// assumes ctl_pkg, ctl_bank and host_model compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // stimulus
  // ****
  logic clk = 0, rst = 1, en, crst, gl, rn;
  logic [2:0] ev = 3'h0;
  logic [7:0] cur = 8'h00, rdata, got, dir, rdy, crc;
  logic [6:0] pv = 7'h00, oe, po;
  ctl_pkg::reg_req_t req;
  int num_errors = 0, comparisons = 0, cyc = 0, seed = 13;
  always #5 clk = ~clk;
  host_model host_model_inst (.clk(clk), .rdata(rdata), .req(req));
  ctl_bank ctl_bank_inst (.clk(clk), .rst(rst), .req(req), .rdata_q(rdata),
    .conv_done(ev[0]), .low_byte_read(ev[1]), .csum_byte_read(ev[2]),
    .csum_current(cur), .csum_enable_q(en), .csum_reset_q(crst),
    .gain_use_last_q(gl), .pin_out_val(pv), .pin_oe_q(oe), .pin_o_q(po),
    .ready_n_q(rn));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // strobes are sampled one edge later; outputs checked after it
  task automatic pulse(input logic [2:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 3'h0;
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host_model_inst.rd(7'h11, got);
    chk(got, 8'h03);
    for (int i = 0; i < 12; i++) begin
      dir = 8'($random(seed));
      rdy = 8'($random(seed));
      crc = 8'($random(seed));
      @(posedge clk) cur <= 8'($random(seed));
      pv <= 7'($random(seed));
      host_model_inst.wr(7'h0e, dir);
      host_model_inst.wr(7'h11, rdy);
      host_model_inst.wr(7'h13, crc);
      #1 chk(8'(en), 8'(crc[4]));
      chk(8'(gl), 8'(rdy[3]));
      chk(8'(oe), 8'(dir[6:0] | {rdy[7], 6'h00}));
      chk(8'(po), 8'({(rdy[7] ? 1'b1 : pv[6]), pv[5:0]}));
      host_model_inst.rd(7'h0e, got);
      chk(got, dir & 8'h7f);
      host_model_inst.rd(7'h11, got);
      chk(got, (rdy & 8'ha8) | 8'h03);
      host_model_inst.rd(7'h13, got);
      chk(got, crc & 8'h14);
      host_model_inst.rd(7'h1d, got);
      chk(got, cur);
      host_model_inst.rd(7'h05, got);
      chk(got, 8'h00);
      pulse(3'h1);
      chk(8'(rn), 8'h00);
      chk(8'(po), 8'({(rdy[7] ? 1'b0 : pv[6]), pv[5:0]}));
      pulse(3'h2);
      chk(8'(rn), {7'h00, !crc[2]});
      chk(8'(crst), {7'h00, (!crc[2] && !rdy[5])});
      pulse(3'h4);
      chk(8'(rn), 8'h01);
      chk(8'(crst), {7'h00, (crc[2] && !rdy[5])});
      host_model_inst.wr(7'h1d, 8'($random(seed)));
      #1 chk(8'(crst), 8'h01);
    end
    test_done();
  end
endmodule
`default_nettype wire
